// [config_access_router.v]
// config_access_router.v: turns host i/o and memory configuration
// accesses into configuration requests and routes them
// assumes: host holds a request until its ack; one access in flight;
// enhanced base, size and bridge bus numbers are driven by config regs
//
// How it works
// - i/o window configuration cycles happen only while index bit 31 is set
// - data window bytes map to the dword named by the index register
// - both mechanisms fill one common request record before routing
// - each function has 4096 bytes; low 256 are the compatible part
// - extended registers reachable only through the memory window
// - either mechanism produces the identical request for one register
// - window below 4 GB, sized 256, 128 or 64 MB for 256/128/64 buses
// - window enable and base come from firmware-set configuration
// - window address is base plus bus, device, function and offset
// - requests carry a 4-bit extended number, zero from i/o window
// - header bytes 8 to 11 carry bus, device, function, ext, register
// - bus field decoded with device; bus zero means a bus-0 target
// - enabled internal bus-0 devices claim their accesses
// - southbridge devices and primary hierarchy go over southbridge link
// - bus equal to bridge secondary gives type 0 on graphics link
// - type 0 on graphics link to nonzero device is master aborted
// - bus inside bridge range but not secondary gives type 1 on graphics
// - memory writes ack at once, forwarded as non-posted writes
// - unclaimed bus-0 access goes to southbridge link as type 0
// - nonzero bus outside bridge range goes to southbridge as type 1
// - byte or word access to index address passes through as plain i/o
// - internal accesses with function above 1 are ignored
`timescale 1ns/1ps
`include "config_router_map.vh"

module config_access_router (
  input  wire        i_clk,
  input  wire        i_rst_b,
  // host front bus i/o side
  input  wire        i_io_req,
  input  wire        i_io_wr,
  input  wire [15:0] i_io_addr,
  input  wire [3:0]  i_io_be,
  input  wire [31:0] i_io_wdata,
  output wire        o_io_ack,
  output wire        o_io_pass,
  output reg  [31:0] o_io_rdata,
  // host front bus memory side
  input  wire        i_mem_req,
  input  wire        i_mem_wr,
  input  wire [31:0] i_mem_addr,
  input  wire [3:0]  i_mem_be,
  input  wire [31:0] i_mem_wdata,
  output wire        o_mem_ack,
  output wire        o_mem_hit,
  output reg  [31:0] o_mem_rdata,
  // configuration held elsewhere
  input  wire        i_ecfg_en,
  input  wire [31:0] i_ecfg_base,
  input  wire [1:0]  i_ecfg_size,
  input  wire [7:0]  i_sec_bus,
  input  wire [7:0]  i_sub_bus,
  input  wire [2:0]  i_int_dev_en,
  // outgoing configuration request
  output wire        o_cfg_valid,
  input  wire        i_cfg_ready,
  output reg  [2:0]  o_cfg_dest,
  output reg         o_cfg_type1,
  output reg         o_cfg_wr,
  output reg  [3:0]  o_cfg_be,
  output reg  [31:0] o_cfg_wdata,
  output reg  [7:0]  o_hdr_b8,
  output reg  [7:0]  o_hdr_b9,
  output reg  [7:0]  o_hdr_b10,
  output reg  [7:0]  o_hdr_b11,
  // completion from the chosen target
  input  wire        i_cpl_valid,
  input  wire        i_cpl_abort,
  input  wire [31:0] i_cpl_data,
  // index register, readable for status
  output wire [31:0] o_idx_value
);

  // =====================================================================
  // states
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_ISSUE = 4'b0010;
  localparam [3:0] S_WAIT  = 4'b0100;
  localparam [3:0] S_RESP  = 4'b1000;

  // =====================================================================
  // reset release through two flops
  reg rst_meta_q;
  reg rst_sync_q;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_b = rst_sync_q;

  // =====================================================================
  // state and request record
  reg [3:0]  state_q;
  reg [31:0] idx_q;
  reg        is_io_q;
  reg        pass_q;
  reg        fwd_q;     // posted write still to be forwarded
  reg        posted_q;  // current forward has no host answer
  reg        drop_q;    // abort or ignore: answer locally

  assign o_idx_value = idx_q;
  assign o_io_ack    = (state_q == S_RESP) && is_io_q;
  assign o_io_pass   = (state_q == S_RESP) && is_io_q && pass_q;
  assign o_mem_ack   = (state_q == S_RESP) && !is_io_q;
  assign o_cfg_valid = (state_q == S_ISSUE) && !drop_q;

  // =====================================================================
  // i/o decode; addresses named so their dword bits can be sliced
  localparam [15:0] IDX_ADDR = `IDX_IO_ADDR;
  localparam [15:0] WIN_ADDR = `WIN_IO_ADDR;
  wire io_idx_dw = (i_io_addr[`IO_DW_MSB:`IO_DW_LSB] ==
                    IDX_ADDR[`IO_DW_MSB:`IO_DW_LSB]);
  wire io_idx_full = (i_io_addr == `IDX_IO_ADDR) && (i_io_be == `BE_FULL);
  wire io_win = (i_io_addr[`IO_DW_MSB:`IO_DW_LSB] ==
                 WIN_ADDR[`IO_DW_MSB:`IO_DW_LSB]);
  wire io_cfg_on = idx_q[`IDX_EN_BIT];

  // =====================================================================
  // enhanced window decode; size trims both hit mask and bus field
  reg [31:0] hit_mask;
  reg [7:0]  bus_mask;
  always @* begin
    case (i_ecfg_size)
      `ECFG_SZ_128MB: begin
        hit_mask = `ECFG_HIT_128MB;
        bus_mask = `BUS_128;
      end
      `ECFG_SZ_64MB: begin
        hit_mask = `ECFG_HIT_64MB;
        bus_mask = `BUS_64;
      end
      default: begin
        hit_mask = `ECFG_HIT_256MB;
        bus_mask = `BUS_ALL;
      end
    endcase
  end
  // the window lives below 4 GB simply because addresses are 32 bits
  assign o_mem_hit = i_ecfg_en &&
                     (((i_mem_addr ^ i_ecfg_base) & hit_mask) ==
                      `ZERO_DW);

  // =====================================================================
  // common request record, filled from whichever mechanism is taken
  reg [7:0] n_bus;
  reg [4:0] n_dev;
  reg [2:0] n_fn;
  reg [3:0] n_ext;
  reg [5:0] n_reg;
  always @* begin
    if (i_io_req) begin
      n_bus = idx_q[`IDX_BUS_MSB:`IDX_BUS_LSB];
      n_dev = idx_q[`IDX_DEV_MSB:`IDX_DEV_LSB];
      n_fn  = idx_q[`IDX_FN_MSB:`IDX_FN_LSB];
      n_ext = `EXT_ZERO;
      n_reg = idx_q[`IDX_REG_MSB:`IDX_REG_LSB];
    end else begin
      n_bus = i_mem_addr[`ECFG_BUS_MSB:`ECFG_BUS_LSB] & bus_mask;
      n_dev = i_mem_addr[`ECFG_DEV_MSB:`ECFG_DEV_LSB];
      n_fn  = i_mem_addr[`ECFG_FN_MSB:`ECFG_FN_LSB];
      n_ext = i_mem_addr[`ECFG_EXT_MSB:`ECFG_EXT_LSB];
      n_reg = i_mem_addr[`ECFG_REG_MSB:`ECFG_REG_LSB];
    end
  end

  // =====================================================================
  // routing of the record about to be captured
  wire [2:0] r_dest;
  wire       r_type1;
  wire       r_abort;
  wire       r_ignore;
  cfg_route_decode u_route (
    .i_bus        (n_bus),
    .i_dev        (n_dev),
    .i_fn         (n_fn),
    .i_sec_bus    (i_sec_bus),
    .i_sub_bus    (i_sub_bus),
    .i_int_dev_en (i_int_dev_en),
    .o_dest       (r_dest),
    .o_type1      (r_type1),
    .o_abort      (r_abort),
    .o_ignore     (r_ignore)
  );

  wire take_io  = i_io_req;
  wire take_mem = !i_io_req && i_mem_req && o_mem_hit;
  wire miss_mem = !i_io_req && i_mem_req && !o_mem_hit;
  wire io_start = take_io && io_win && io_cfg_on;
  wire start    = io_start || take_mem;

  // =====================================================================
  // main sequencer; i/o wins when both sides ask in the same cycle
  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= S_IDLE;
      idx_q       <= `IDX_RESET;
      is_io_q     <= 1'b0;
      pass_q      <= 1'b0;
      fwd_q       <= 1'b0;
      posted_q    <= 1'b0;
      drop_q      <= 1'b0;
      o_io_rdata  <= `ZERO_DW;
      o_mem_rdata <= `ZERO_DW;
      o_cfg_dest  <= `DEST_NONE;
      o_cfg_type1 <= 1'b0;
      o_cfg_wr    <= 1'b0;
      o_cfg_be    <= 4'h0;
      o_cfg_wdata <= `ZERO_DW;
      o_hdr_b8    <= 8'h00;
      o_hdr_b9    <= 8'h00;
      o_hdr_b10   <= 8'h00;
      o_hdr_b11   <= 8'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          pass_q   <= 1'b0;
          posted_q <= 1'b0;
          fwd_q    <= 1'b0;
          if (take_io) begin
            is_io_q <= 1'b1;
            state_q <= S_RESP;
            if (io_idx_full) begin
              if (i_io_wr) begin
                idx_q <= i_io_wdata & `IDX_WMASK;
              end else begin
                o_io_rdata <= idx_q;
              end
            end else if (io_idx_dw) begin
              pass_q <= 1'b1;
            end else if (io_start) begin
              state_q <= S_ISSUE;
            end else begin
              pass_q <= 1'b1;
            end
          end else if (take_mem) begin
            is_io_q <= 1'b0;
            if (i_mem_wr) begin
              // posted toward the host, forwarded after the ack
              state_q  <= S_RESP;
              fwd_q    <= 1'b1;
              posted_q <= 1'b1;
            end else begin
              state_q <= S_ISSUE;
            end
          end else if (miss_mem) begin
            // outside the window: not ours, answered empty
            is_io_q     <= 1'b0;
            o_mem_rdata <= `ALL_ONES;
            state_q     <= S_RESP;
          end
          if (start) begin
            // one record for both mechanisms; header laid out alike
            o_cfg_dest  <= r_dest;
            o_cfg_type1 <= r_type1;
            o_cfg_wr    <= take_io ? i_io_wr : i_mem_wr;
            o_cfg_be    <= take_io ? i_io_be : i_mem_be;
            o_cfg_wdata <= take_io ? i_io_wdata : i_mem_wdata;
            o_hdr_b8    <= n_bus;
            o_hdr_b9    <= {n_dev, n_fn};
            o_hdr_b10   <= {4'h0, n_ext};
            o_hdr_b11   <= {n_reg, 2'b00};
            drop_q      <= r_abort || r_ignore;
          end
        end
        S_ISSUE: begin
          if (drop_q) begin
            // aborted or ignored: reads see all ones, writes vanish
            o_io_rdata  <= `ALL_ONES;
            o_mem_rdata <= `ALL_ONES;
            state_q     <= posted_q ? S_IDLE : S_RESP;
          end else if (i_cfg_ready) begin
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          // writes on the links are non-posted, so wait for completion
          if (i_cpl_valid) begin
            o_io_rdata  <= i_cpl_abort ? `ALL_ONES : i_cpl_data;
            o_mem_rdata <= i_cpl_abort ? `ALL_ONES : i_cpl_data;
            state_q     <= posted_q ? S_IDLE : S_RESP;
          end
        end
        S_RESP: begin
          fwd_q   <= 1'b0;
          state_q <= fwd_q ? S_ISSUE : S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// [config_router_map.vh]
// config_router_map.vh: offsets, field positions and codes of the router
// assumes: included by the router sources; definitions only, no logic
`ifndef CONFIG_ROUTER_MAP_VH
`define CONFIG_ROUTER_MAP_VH

// =====================================================================
// i/o addresses of the index register and the data window
`define IDX_IO_ADDR    16'h0cf8
`define WIN_IO_ADDR    16'h0cfc
`define IO_DW_MSB      15
`define IO_DW_LSB      2
`define BE_FULL        4'hf

// =====================================================================
// index register layout and reset value
`define IDX_RESET      32'h0000_0000
`define IDX_WMASK      32'h80ff_fffc
`define IDX_EN_BIT     31
`define IDX_BUS_MSB    23
`define IDX_BUS_LSB    16
`define IDX_DEV_MSB    15
`define IDX_DEV_LSB    11
`define IDX_FN_MSB     10
`define IDX_FN_LSB     8
`define IDX_REG_MSB    7
`define IDX_REG_LSB    2

// =====================================================================
// enhanced region address layout: bus 1 MB, dev 32 KB, fn 4 KB
`define ECFG_BUS_MSB   27
`define ECFG_BUS_LSB   20
`define ECFG_DEV_MSB   19
`define ECFG_DEV_LSB   15
`define ECFG_FN_MSB    14
`define ECFG_FN_LSB    12
`define ECFG_EXT_MSB   11
`define ECFG_EXT_LSB   8
`define ECFG_REG_MSB   7
`define ECFG_REG_LSB   2
`define ECFG_SZ_256MB  2'h0
`define ECFG_SZ_128MB  2'h1
`define ECFG_SZ_64MB   2'h2
`define ECFG_HIT_256MB 32'hf000_0000
`define ECFG_HIT_128MB 32'hf800_0000
`define ECFG_HIT_64MB  32'hfc00_0000
`define BUS_ALL        8'hff
`define BUS_128        8'h7f
`define BUS_64         8'h3f

// =====================================================================
// routing codes, one-hot destination and misc constants
`define DEST_INT       3'h1
`define DEST_GFX       3'h2
`define DEST_SB        3'h4
`define DEST_NONE      3'h0
`define INT_DEV_CNT    5'h03
`define DEV_ZERO       5'h00
`define BUS_ZERO       8'h00
`define FN_MAX_INT     3'h1
`define EXT_ZERO       4'h0
`define ALL_ONES       32'hffff_ffff
`define ZERO_DW        32'h0000_0000

`endif

// [cfg_route_decode.v]
// cfg_route_decode.v: picks the target of one configuration request
// assumes: purely combinational; bridge bus numbers come from outside
`timescale 1ns/1ps
`include "config_router_map.vh"

module cfg_route_decode (
  input  wire [7:0] i_bus,
  input  wire [4:0] i_dev,
  input  wire [2:0] i_fn,
  input  wire [7:0] i_sec_bus,
  input  wire [7:0] i_sub_bus,
  input  wire [2:0] i_int_dev_en,
  output reg  [2:0] o_dest,
  output reg        o_type1,
  output reg        o_abort,
  output reg        o_ignore
);

  // =====================================================================
  // bus-0 claim, graphics bridge range, subtractive southbridge default
  always @* begin
    o_dest   = `DEST_SB;
    o_type1  = 1'b0;
    o_abort  = 1'b0;
    o_ignore = 1'b0;
    if (i_bus == `BUS_ZERO) begin
      if ((i_dev < `INT_DEV_CNT) && i_int_dev_en[i_dev[1:0]]) begin
        if (i_fn > `FN_MAX_INT) begin
          o_ignore = 1'b1;
          o_dest   = `DEST_NONE;
        end else begin
          o_dest = `DEST_INT;
        end
      end else begin
        o_dest = `DEST_SB;
      end
    end else if (i_bus == i_sec_bus) begin
      o_dest = `DEST_GFX;
      if (i_dev != `DEV_ZERO) begin
        o_abort = 1'b1;
        o_dest  = `DEST_NONE;
      end
    end else if ((i_bus > i_sec_bus) && (i_bus <= i_sub_bus)) begin
      o_dest  = `DEST_GFX;
      o_type1 = 1'b1;
    end else begin
      o_dest  = `DEST_SB;
      o_type1 = 1'b1;
    end
  end

endmodule

// [router_sva.sv]
// router_sva.sv: concurrent checks on the router's ports
// assumes: bound to config_access_router; one clock, async low reset
`timescale 1ns/1ps
`include "config_router_map.vh"

// ====================
// port checker
module router_sva (
  input wire        i_clk,
  input wire        i_rst_b,
  input wire        i_io_req,
  input wire        i_io_wr,
  input wire [15:0] i_io_addr,
  input wire [3:0]  i_io_be,
  input wire [31:0] i_io_wdata,
  input wire        o_io_ack,
  input wire        o_io_pass,
  input wire        i_mem_req,
  input wire        i_mem_wr,
  input wire [31:0] i_mem_addr,
  input wire        o_mem_ack,
  input wire        o_mem_hit,
  input wire        i_ecfg_en,
  input wire [31:0] i_ecfg_base,
  input wire [1:0]  i_ecfg_size,
  input wire [7:0]  i_sec_bus,
  input wire [7:0]  i_sub_bus,
  input wire [2:0]  i_int_dev_en,
  input wire        o_cfg_valid,
  input wire        i_cfg_ready,
  input wire [2:0]  o_cfg_dest,
  input wire        o_cfg_type1,
  input wire        o_cfg_wr,
  input wire [7:0]  o_hdr_b8,
  input wire [7:0]  o_hdr_b9,
  input wire [7:0]  o_hdr_b10,
  input wire [7:0]  o_hdr_b11,
  input wire [31:0] o_idx_value
);
  // window size picks address mask and bus mask
  wire [31:0] hit_msk = (i_ecfg_size == `ECFG_SZ_128MB) ? `ECFG_HIT_128MB :
    (i_ecfg_size == `ECFG_SZ_64MB) ? `ECFG_HIT_64MB : `ECFG_HIT_256MB;
  wire [7:0]  bus_msk = (i_ecfg_size == `ECFG_SZ_128MB) ? `BUS_128 :
    (i_ecfg_size == `ECFG_SZ_64MB) ? `BUS_64 : `BUS_ALL;
  wire [31:0] hdr = {o_hdr_b8, o_hdr_b9, o_hdr_b10, o_hdr_b11};
  wire [4:0]  hdev = o_hdr_b9[7:3];
  wire        fwd = o_cfg_valid;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_window_decode: assert property (
    i_mem_req |-> o_mem_hit == (i_ecfg_en &&
      ((i_mem_addr & hit_msk) == (i_ecfg_base & hit_msk))))
    else $error("memory window decode wrong");
  a_index_load: assert property (
    o_io_ack && i_io_wr && i_io_addr == `IDX_IO_ADDR && i_io_be == `BE_FULL
    |-> o_idx_value == (i_io_wdata & `IDX_WMASK))
    else $error("index not loaded");
  a_narrow_pass: assert property (
    o_io_ack && i_io_addr[15:2] == 14'h033e &&
    (i_io_be != `BE_FULL || i_io_addr[1:0] != 2'h0)
    |-> o_io_pass && $stable(o_idx_value))
    else $error("narrow index access not passed");
  a_window_gate: assert property (
    o_io_ack && !o_io_pass && i_io_addr[15:2] == 14'h033f |-> o_idx_value[31])
    else $error("window used while disabled");
  a_io_header: assert property (
    $rose(o_cfg_valid) && $past(i_io_req) |->
    hdr == {o_idx_value[23:8], 8'h00, o_idx_value[7:2], 2'b00})
    else $error("io request header wrong");
  a_mem_header: assert property (
    $rose(o_cfg_valid) && $past(i_mem_req) && !$past(i_io_req) |->
    hdr == $past({i_mem_addr[27:20] & bus_msk, i_mem_addr[19:12], 4'h0,
      i_mem_addr[11:2], 2'b00}))
    else $error("memory request header wrong");
  a_posted_write: assert property (
    o_mem_ack && i_mem_wr && o_mem_hit |=> fwd && o_cfg_wr)
    else $error("posted write not forwarded");
  a_gfx_type0: assert property (
    fwd && o_cfg_dest == `DEST_GFX && !o_cfg_type1
    |-> o_hdr_b8 == i_sec_bus && hdev == `DEV_ZERO)
    else $error("graphics type 0 wrong");
  a_gfx_type1: assert property (
    fwd && o_cfg_dest == `DEST_GFX && o_cfg_type1
    |-> o_hdr_b8 > i_sec_bus && o_hdr_b8 <= i_sub_bus)
    else $error("graphics type 1 wrong");
  a_sb_type: assert property (
    fwd && o_cfg_dest == `DEST_SB |-> o_cfg_type1 == (o_hdr_b8 != `BUS_ZERO)
    && !(o_hdr_b8 == `BUS_ZERO && hdev < `INT_DEV_CNT &&
    i_int_dev_en[hdev[1:0]]))
    else $error("southbridge route wrong");
  a_int_claim: assert property (
    fwd && o_cfg_dest == `DEST_INT |-> o_hdr_b8 == `BUS_ZERO &&
    !o_cfg_type1 && hdev < `INT_DEV_CNT && i_int_dev_en[hdev[1:0]] &&
    o_hdr_b9[2:0] <= `FN_MAX_INT)
    else $error("internal claim wrong");
  a_req_hold: assert property (
    fwd && !i_cfg_ready |=> fwd && $stable(hdr) && $stable(o_cfg_dest))
    else $error("request dropped before taken");

  c_pass: cover property (o_io_ack && o_io_pass);
  c_slow: cover property (fwd && !i_cfg_ready);
  c_posted: cover property (o_mem_ack && i_mem_wr && o_mem_hit);
endmodule

bind config_access_router router_sva chk_u (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_io_req(i_io_req), .i_io_wr(i_io_wr),
  .i_io_addr(i_io_addr), .i_io_be(i_io_be), .i_io_wdata(i_io_wdata),
  .o_io_ack(o_io_ack), .o_io_pass(o_io_pass), .i_mem_req(i_mem_req),
  .i_mem_wr(i_mem_wr), .i_mem_addr(i_mem_addr), .o_mem_ack(o_mem_ack),
  .o_mem_hit(o_mem_hit), .i_ecfg_en(i_ecfg_en), .i_ecfg_base(i_ecfg_base),
  .i_ecfg_size(i_ecfg_size), .i_sec_bus(i_sec_bus), .i_sub_bus(i_sub_bus),
  .i_int_dev_en(i_int_dev_en), .o_cfg_valid(o_cfg_valid),
  .i_cfg_ready(i_cfg_ready), .o_cfg_dest(o_cfg_dest),
  .o_cfg_type1(o_cfg_type1), .o_cfg_wr(o_cfg_wr), .o_hdr_b8(o_hdr_b8),
  .o_hdr_b9(o_hdr_b9), .o_hdr_b10(o_hdr_b10), .o_hdr_b11(o_hdr_b11),
  .o_idx_value(o_idx_value)
);

// [tgt_model.sv]
// tgt_model.sv: far-side target taking configuration requests
// assumes: one request at a time; i_slow sets wait cycles for ready and cpl
`timescale 1ns/1ps

// ====================
// target model
module tgt_model (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire [3:0]  i_slow,
  input  wire        i_valid,
  output reg         o_ready,
  input  wire        i_wr,
  input  wire [3:0]  i_be,
  input  wire [31:0] i_wdata,
  input  wire [31:0] i_hdr,
  input  wire [2:0]  i_dest,
  input  wire        i_type1,
  output reg         o_cpl_valid,
  output reg  [31:0] o_cpl_data,
  output reg  [35:0] o_last,
  output reg  [7:0]  o_cnt
);
  reg [31:0] mem_q [0:1023];
  reg        busy_q;
  reg [3:0]  wait_q;
  reg [9:0]  key_q;
  integer    k;

  // byte lanes merge, untouched lanes keep old contents
  function [31:0] merge(input [31:0] o, input [31:0] n, input [3:0] b);
    integer j;
    begin
      merge = o;
      for (j = 0; j < 4; j = j + 1)
        if (b[j]) merge[8*j +: 8] = n[8*j +: 8];
    end
  endfunction

  // register store, shared by all targets so mechanisms meet
  initial begin
    for (k = 0; k < 1024; k = k + 1) mem_q[k] = 32'h0000_0000;
  end

  // take, wait, complete; idle data flips so stale data never matches
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready <= 1'b1;
      o_cpl_valid <= 1'b0;
      o_cpl_data <= 32'h0000_0000;
      o_last <= 36'h0_0000_0000;
      o_cnt <= 8'h00;
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      key_q <= 10'h000;
    end else begin
      o_cpl_valid <= 1'b0;
      o_cpl_data <= ~o_cpl_data;
      if (!busy_q && i_valid && o_ready) begin
        busy_q <= 1'b1;
        o_ready <= 1'b0;
        wait_q <= 4'h0;
        key_q <= {i_hdr[11:8], i_hdr[7:2]};
        o_last <= {i_dest, i_type1, i_hdr};
        o_cnt <= o_cnt + 8'h01;
        if (i_wr) mem_q[{i_hdr[11:8], i_hdr[7:2]}] <=
          merge(mem_q[{i_hdr[11:8], i_hdr[7:2]}], i_wdata, i_be);
      end else if (!busy_q && i_valid) begin
        wait_q <= wait_q + 4'h1;
        o_ready <= (wait_q >= i_slow);
      end else if (busy_q && wait_q >= i_slow) begin
        busy_q <= 1'b0;
        o_cpl_valid <= 1'b1;
        o_cpl_data <= mem_q[key_q];
        o_ready <= (i_slow == 4'h0);
        wait_q <= 4'h0;
      end else if (busy_q) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// [config_access_router_tb.sv]
// config_access_router_tb.sv: directed tests of the router
// assumes: far side is tgt_model; inputs change on the falling edge
`timescale 1ns/1ps
`include "config_router_map.vh"

module config_access_router_tb;
  reg         i_clk, i_rst_b, io_req, io_wr, mem_req, mem_wr, ecfg_en;
  reg  [15:0] io_addr;
  reg  [3:0]  io_be, mem_be, slow;
  reg  [31:0] io_wdata, mem_addr, mem_wdata, ecfg_base, rd;
  reg  [1:0]  ecfg_size;
  reg  [7:0]  c0;
  reg  [19:0] tbl [0:9];
  reg  [19:0] e;
  reg         ps;
  wire        io_ack, io_pass, mem_ack, cfg_valid, cfg_ready, cfg_t1, cfg_wr;
  wire        cpl_valid;
  wire [31:0] io_rdata, mem_rdata, cfg_wdata, cpl_data, idx_value;
  wire [2:0]  cfg_dest;
  wire [3:0]  cfg_be;
  wire [7:0]  b8, b9, b10, b11, cnt;
  wire [35:0] last;
  integer     errors, checked, i;

  config_access_router dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_io_req(io_req), .i_io_wr(io_wr),
    .i_io_addr(io_addr), .i_io_be(io_be), .i_io_wdata(io_wdata),
    .o_io_ack(io_ack), .o_io_pass(io_pass), .o_io_rdata(io_rdata),
    .i_mem_req(mem_req), .i_mem_wr(mem_wr), .i_mem_addr(mem_addr),
    .i_mem_be(mem_be), .i_mem_wdata(mem_wdata), .o_mem_ack(mem_ack),
    .o_mem_hit(), .o_mem_rdata(mem_rdata), .i_ecfg_en(ecfg_en),
    .i_ecfg_base(ecfg_base), .i_ecfg_size(ecfg_size), .i_sec_bus(8'h01),
    .i_sub_bus(8'h04), .i_int_dev_en(3'h3), .o_cfg_valid(cfg_valid),
    .i_cfg_ready(cfg_ready), .o_cfg_dest(cfg_dest), .o_cfg_type1(cfg_t1),
    .o_cfg_wr(cfg_wr), .o_cfg_be(cfg_be), .o_cfg_wdata(cfg_wdata),
    .o_hdr_b8(b8), .o_hdr_b9(b9), .o_hdr_b10(b10), .o_hdr_b11(b11),
    .i_cpl_valid(cpl_valid), .i_cpl_abort(1'b0), .i_cpl_data(cpl_data),
    .o_idx_value(idx_value));

  tgt_model tgt_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_slow(slow), .i_valid(cfg_valid),
    .o_ready(cfg_ready), .i_wr(cfg_wr), .i_be(cfg_be), .i_wdata(cfg_wdata),
    .i_hdr({b8, b9, b10, b11}), .i_dest(cfg_dest), .i_type1(cfg_t1),
    .o_cpl_valid(cpl_valid), .o_cpl_data(cpl_data), .o_last(last),
    .o_cnt(cnt));

  // ====================
  // clock, watchdog
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // runs take a few hundred cycles; the limit of 20000 cycles is far above that
  initial begin
    #160000;
    errors = errors + 1;
    end_sim;
  end

  // ====================
  // tasks
  task chk(input [35:0] got, input [35:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one host access, held until ack, dropped the cycle after
  task acc(input m, input w, input [31:0] a, input [3:0] be, input [31:0] d);
    integer n;
    begin
      @(negedge i_clk);
      if (m) {mem_req, mem_wr, mem_addr, mem_be, mem_wdata} =
        {1'b1, w, a, be, d};
      else {io_req, io_wr, io_addr, io_be, io_wdata} =
        {1'b1, w, a[15:0], be, d};
      n = 0;
      while ((m ? mem_ack : io_ack) !== 1'b1 && n < 200) begin
        @(negedge i_clk);
        n = n + 1;
      end
      if (n >= 200) chk(36'h0_0000_0000, 36'h0_0000_0001);
      rd = m ? mem_rdata : io_rdata;
      ps = io_pass;
      @(negedge i_clk);
      io_req = 1'b0;
      mem_req = 1'b0;
    end
  endtask
  task do_rst;
    begin
      i_rst_b = 1'b0;
      repeat (4) @(negedge i_clk);
      i_rst_b = 1'b1;
      repeat (3) @(negedge i_clk);
    end
  endtask
  task end_sim;
    begin
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // ====================
  // tests
  initial begin
    {io_req, io_wr, mem_req, mem_wr, ecfg_en, ecfg_size} = 7'h00;
    {io_addr, io_be, mem_be, io_wdata, mem_addr, mem_wdata} = 0;
    {ecfg_base, slow, errors, checked} = 0;
    // {bus, dev, fn} word, dest, type1
    tbl[0] = {16'h0000, `DEST_INT, 1'b0};
    tbl[1] = {16'h0009, `DEST_INT, 1'b0};
    tbl[2] = {16'h0010, `DEST_SB, 1'b0};
    tbl[3] = {16'h003b, `DEST_SB, 1'b0};
    tbl[4] = {16'h0102, `DEST_GFX, 1'b0};
    tbl[5] = {16'h0321, `DEST_GFX, 1'b1};
    tbl[6] = {16'h0400, `DEST_GFX, 1'b1};
    tbl[7] = {16'h0510, `DEST_SB, 1'b1};
    tbl[8] = {16'h0118, `DEST_NONE, 1'b0};
    tbl[9] = {16'h000a, `DEST_NONE, 1'b0};
    do_rst;
    chk(idx_value, `IDX_RESET);
    acc(0, 1, `IDX_IO_ADDR, `BE_FULL, `ALL_ONES);
    chk(idx_value, `IDX_WMASK);
    acc(0, 1, `IDX_IO_ADDR, 4'h1, 32'h0000_0000);
    chk({ps, idx_value}, {1'b1, `IDX_WMASK});
    acc(0, 1, `IDX_IO_ADDR, `BE_FULL, 32'h0000_0104);
    c0 = cnt;
    acc(0, 0, `WIN_IO_ADDR, `BE_FULL, 32'h0000_0000);
    chk({ps, cnt - c0}, 9'h100);
    $display("index tests done, errors %0d", errors);
    // every route, prompt far side
    for (i = 0; i < 10; i = i + 1) begin
      e = tbl[i];
      acc(0, 1, `IDX_IO_ADDR, `BE_FULL,
        {8'h80, e[19:4], i[5:0], 2'b00});
      c0 = cnt;
      acc(0, 1, `WIN_IO_ADDR, `BE_FULL, 32'h5a00_0000 | i);
      acc(0, 0, `WIN_IO_ADDR, `BE_FULL, 32'h0000_0000);
      if (e[3:1] == `DEST_NONE) begin
        chk({28'h0, cnt - c0}, 36'h0);
        chk(rd, `ALL_ONES);
      end else begin
        chk({28'h0, cnt - c0}, 36'h2);
        chk(rd, 32'h5a00_0000 | i);
        chk(last, {e[3:0], e[19:4], 8'h00, i[5:0], 2'b00});
      end
    end
    $display("routing tests done, errors %0d", errors);
    // enhanced window, slow far side; aligned, never locked
    {ecfg_en, ecfg_base, slow} = {1'b1, 32'he000_0000, 4'h5};
    c0 = cnt;
    acc(1, 1, 32'he032_5240, `BE_FULL, 32'h1234_5678);
    acc(1, 0, 32'he032_5240, `BE_FULL, 32'h0000_0000);
    chk(rd, 32'h1234_5678);
    chk({28'h0, cnt - c0}, 36'h2);
    chk(last, {`DEST_GFX, 1'b1, 8'h03, 8'h25, 8'h02, 8'h40});
    acc(1, 1, 32'he032_5240, 4'h3, `ALL_ONES);
    acc(1, 0, 32'he032_5240, `BE_FULL, 32'h0000_0000);
    chk(rd, 32'h1234_ffff);
    acc(1, 1, 32'he000_0008, `BE_FULL, 32'hcafe_0001);
    acc(0, 1, `IDX_IO_ADDR, `BE_FULL, 32'h8000_0008);
    acc(0, 0, `WIN_IO_ADDR, `BE_FULL, 32'h0000_0000);
    chk(rd, 32'hcafe_0001);
    chk(last, {`DEST_INT, 1'b0, 24'h00_0000, 8'h08});
    for (i = 0; i < 3; i = i + 1) begin
      ecfg_size = i[1:0];
      c0 = cnt;
      acc(1, 0, 32'he500_0000, `BE_FULL, 32'h0000_0000);
      chk({28'h0, cnt - c0}, (i < 2) ? 36'h1 : 36'h0);
    end
    {ecfg_en, ecfg_size} = 3'h0;
    acc(1, 0, 32'he032_5240, `BE_FULL, 32'h0000_0000);
    chk(rd, `ALL_ONES);
    $display("enhanced tests done, errors %0d", errors);
    do_rst;
    chk(idx_value, `IDX_RESET);
    $display("reset test done, errors %0d", errors);
    end_sim;
  end
endmodule
